/* pin_mux_map.vh */
/*
 * Shared pin selection constants: pin indices within each port and the
 * reset value of the registered pin controls.
 * Assumes it is included by its bare name from the pin selection module.
 */
`ifndef PIN_MUX_MAP_VH
`define PIN_MUX_MAP_VH

// Port A line indices
`define PA_LINE0        0
`define PA_LINE1        1
`define PA_LINE2        2
`define PA_LINE3        3
`define PA_LINE4        4
`define PA_LINE5        5
// Port B line indices
`define PB_LINE0        0
`define PB_LINE4        4
`define PB_LINE6        6
// Reset value of all pin output enables and data (all inputs)
`define PA_RESET        6'h00
`define PB_RESET        8'h00

`endif

/* shared_pin_priority_mux.v */
/*
 * Shared pin priority selection for port A (6 lines) and port B (8 lines).
 * Each pin picks one driver from its candidate functions in fixed
 * priority order; every pin output is registered.
 * Assumes all inputs are synchronous to clk and that each peripheral
 * presents an enable, an output enable and output data for its pin.
 */
`timescale 1ns/100ps
`include "pin_mux_map.vh"

module shared_pin_priority_mux (
    input  wire       clk,
    input  wire       rstn,
    // Port data direction and output registers from the port block
    input  wire [5:0] port_a_ddr,
    input  wire [5:0] port_a_dout,
    input  wire [7:0] port_b_ddr,
    input  wire [7:0] port_b_dout,
    // Analog channel selects, one per shared pin
    input  wire [5:0] analog_sel_a,
    input  wire [7:0] analog_sel_b,
    // Timer channels 0..3 on PA0, PA1, PB6, PB7
    input  wire [3:0] timer_chan_en,
    input  wire [3:0] timer_chan_oe,
    input  wire [3:0] timer_chan_out,
    input  wire       timer_ext_clock_en,
    // Keyboard interrupt enables for PA0..PA5
    input  wire [5:0] key_irq_en,
    // External interrupt and external reset pin functions
    input  wire       ext_irq_en,
    input  wire       ext_reset_en,
    // Oscillator functions
    input  wire       oscillator_in_en,
    input  wire       xtal_out_en,
    input  wire       xtal_out,
    input  wire       osc_out_pin_enable,
    input  wire       rc_clock,
    // SPI on PB0..PB3 and serial port on PB4/PB5
    input  wire       spi_en,
    input  wire [3:0] spi_oe,
    input  wire [3:0] spi_out,
    input  wire       serial_en,
    input  wire [1:0] serial_oe,
    input  wire [1:0] serial_out,
    // Pin levels
    input  wire [5:0] port_a_pin_in,
    input  wire [7:0] port_b_pin_in,
    // Registered pin drivers, output enable high while driving
    output reg  [5:0] port_a_oe_r,
    output reg  [5:0] port_a_out_r,
    output reg  [7:0] port_b_oe_r,
    output reg  [7:0] port_b_out_r,
    // Registered owner flags seen by the peripherals
    output reg  [5:0] key_irq_line_r,
    output reg        ext_irq_line_r,
    output reg        ext_reset_line_r,
    output reg        timer_ext_clock_in_r,
    output reg        oscillator_in_r
);

    reg [5:0] pa_oe_nxt;                // Next port A output enables
    reg [5:0] pa_out_nxt;               // Next port A output data
    reg [7:0] pb_oe_nxt;                // Next port B output enables
    reg [7:0] pb_out_nxt;               // Next port B output data
    reg [5:0] kbi_nxt;                  // Next keyboard input samples
    integer   i;                        // Loop index over pins of one port

    // Every pin is resolved in one combinational pass and then registered.
    // Registering costs one cycle of latency on every pin function, but it
    // keeps the pad drivers glitch free while several enables change at
    // once, which matters more for open pins than the extra cycle.
    //
    // A losing function never reaches the pad: only the winner's output
    // enable and data are copied into the next values, everything else
    // stays at the idle default set at the top of the process.
    //
    // Limitation: the analog select masks the lower functions on its pin
    // but does not switch them off upstream; a peripheral that is still
    // enabled keeps running and simply loses the pin.
    //
    // The keyboard, interrupt, reset, timer clock and oscillator owner
    // lines carry the pin level only while their function owns the pin,
    // so a peripheral that has lost the pin sees a steady low instead of
    // a level that someone else is driving.

    // Port pin fallback: drive only when direction is output
    function [1:0] port_drive;
        input ddr;
        input dout;
        begin
            port_drive = {ddr, dout};
        end
    endfunction

    // Priority resolution for every shared pin
    always @* begin
        pa_oe_nxt  = 6'h00;
        pa_out_nxt = 6'h00;
        pb_oe_nxt  = 8'h00;
        pb_out_nxt = 8'h00;
        kbi_nxt    = 6'h00;
        // PA0 and PA1; analog select only blocks lower functions here
        for (i = `PA_LINE0; i <= `PA_LINE1; i = i + 1) begin
            if (analog_sel_a[i]) begin
                // Pin stays undriven while sampled by the converter
            end else if (timer_chan_en[i]) begin
                pa_oe_nxt[i]  = timer_chan_oe[i];
                pa_out_nxt[i] = timer_chan_out[i];
            end else if (key_irq_en[i]) begin
                kbi_nxt[i] = port_a_pin_in[i];
            end else begin
                {pa_oe_nxt[i], pa_out_nxt[i]} = port_drive(port_a_ddr[i], port_a_dout[i]);
            end
        end
        // PA2 is input only; key irq sees it unless higher owns it
        if (!ext_irq_en && !timer_ext_clock_en && key_irq_en[`PA_LINE2]) begin
            kbi_nxt[`PA_LINE2] = port_a_pin_in[`PA_LINE2];
        end
        // PA3 under the reset pin function is never driven
        if (!ext_reset_en) begin
            if (key_irq_en[`PA_LINE3]) begin
                kbi_nxt[`PA_LINE3] = port_a_pin_in[`PA_LINE3];
            end else begin
                {pa_oe_nxt[3], pa_out_nxt[3]} = port_drive(port_a_ddr[3], port_a_dout[3]);
            end
        end
        // PA4: oscillator output (RC clock) first, crystal output when enabled
        if (osc_out_pin_enable) begin
            pa_oe_nxt[4]  = 1'b1;
            pa_out_nxt[4] = rc_clock;
        end else if (xtal_out_en) begin
            pa_oe_nxt[4]  = 1'b1;
            pa_out_nxt[4] = xtal_out;
        end else if (analog_sel_a[`PA_LINE4]) begin
            // Converter input, pin undriven
        end else if (key_irq_en[`PA_LINE4]) begin
            kbi_nxt[`PA_LINE4] = port_a_pin_in[`PA_LINE4];
        end else begin
            {pa_oe_nxt[4], pa_out_nxt[4]} = port_drive(port_a_ddr[4], port_a_dout[4]);
        end
        // PA5: oscillator input owns the pin
        if (!oscillator_in_en && !analog_sel_a[`PA_LINE5]) begin
            if (key_irq_en[`PA_LINE5]) begin
                kbi_nxt[`PA_LINE5] = port_a_pin_in[`PA_LINE5];
            end else begin
                {pa_oe_nxt[5], pa_out_nxt[5]} = port_drive(port_a_ddr[5], port_a_dout[5]);
            end
        end
        // PB0..PB5: analog, then SPI or serial, then port
        for (i = `PB_LINE0; i < `PB_LINE6; i = i + 1) begin
            if (analog_sel_b[i]) begin
                // Converter input; pin left undriven by lower functions
            end else if (i < `PB_LINE4 && spi_en) begin
                pb_oe_nxt[i]  = spi_oe[i];
                pb_out_nxt[i] = spi_out[i];
            end else if (i >= `PB_LINE4 && serial_en) begin
                pb_oe_nxt[i]  = serial_oe[i-4];
                pb_out_nxt[i] = serial_out[i-4];
            end else begin
                {pb_oe_nxt[i], pb_out_nxt[i]} = port_drive(port_b_ddr[i], port_b_dout[i]);
            end
        end
        // PB6, PB7: timer channels 2 and 3 over port
        for (i = `PB_LINE6; i < 8; i = i + 1) begin
            if (timer_chan_en[i-4]) begin
                pb_oe_nxt[i]  = timer_chan_oe[i-4];
                pb_out_nxt[i] = timer_chan_out[i-4];
            end else begin
                {pb_oe_nxt[i], pb_out_nxt[i]} = port_drive(port_b_ddr[i], port_b_dout[i]);
            end
        end
    end

    // Registered drivers; reset forces every pin to input
    // Analog selects never clear peripheral enables upstream;
    // software is expected to disable sharers itself
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            port_a_oe_r          <= `PA_RESET;
            port_a_out_r         <= `PA_RESET;
            port_b_oe_r          <= `PB_RESET;
            port_b_out_r         <= `PB_RESET;
            key_irq_line_r       <= `PA_RESET;
            ext_irq_line_r       <= 1'b0;
            ext_reset_line_r     <= 1'b0;
            timer_ext_clock_in_r <= 1'b0;
            oscillator_in_r      <= 1'b0;
        end else begin
            port_a_oe_r          <= pa_oe_nxt;
            port_a_out_r         <= pa_out_nxt;
            port_b_oe_r          <= pb_oe_nxt;
            port_b_out_r         <= pb_out_nxt;
            key_irq_line_r       <= kbi_nxt;
            ext_irq_line_r       <= ext_irq_en & port_a_pin_in[`PA_LINE2];
            ext_reset_line_r     <= ext_reset_en & port_a_pin_in[`PA_LINE3];
            timer_ext_clock_in_r <= timer_ext_clock_en & !ext_irq_en &
                                    port_a_pin_in[`PA_LINE2];
            oscillator_in_r      <= oscillator_in_en & port_a_pin_in[`PA_LINE5];
        end
    end

endmodule

/* pin_board.sv */
/* Board model for the shared pins.
   Assumes oe high means the chip drives; elsewhere the board level shows. */
`timescale 1ns/100ps
module pin_board (
    input  wire [13:0] oe,
    input  wire [13:0] dout,
    input  wire [13:0] ext,
    output wire [13:0] pin
);
    // The chip wins where it drives, so a wrong enable shows up as a wrong level
    assign pin = (oe & dout) | (~oe & ext);
endmodule

/* pin_mux_chk_assertions.sv */
/* Port checker for the pin selection block.
   Assumes it is bound to shared_pin_priority_mux and sees only its ports. */
`timescale 1ns/100ps
module pin_mux_chk (
    input wire       clk,
    input wire       rstn,
    input wire       ext_irq_en,
    input wire       ext_reset_en,
    input wire       oscillator_in_en,
    input wire       osc_out_pin_enable,
    input wire       rc_clock,
    input wire       spi_en,
    input wire       serial_en,
    input wire [1:0] serial_oe,
    input wire       ext_irq_line_r,
    input wire       timer_ext_clock_in_r,
    input wire       oscillator_in_r,
    input wire [3:0] timer_chan_en,
    input wire [3:0] timer_chan_oe,
    input wire [3:0] spi_oe,
    input wire [5:0] analog_sel_a,
    input wire [5:0] port_a_pin_in,
    input wire [5:0] port_a_oe_r,
    input wire [5:0] port_a_out_r,
    input wire [5:0] key_irq_line_r,
    input wire [7:0] analog_sel_b,
    input wire [7:0] port_b_oe_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Reset check keeps no disable, it must hold while reset is low
    property p_rst; disable iff (1'b0) !rstn |-> port_a_oe_r == 6'h00 && port_b_oe_r == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("pin driven in reset");
    property p_pa0; analog_sel_a[0] |=> !port_a_oe_r[0]; endproperty
    a_pa0: assert property (p_pa0) else $error("pa0 driven under analog");
    property p_irq; ext_irq_en |=> !timer_ext_clock_in_r && ext_irq_line_r == $past(port_a_pin_in[2]); endproperty
    a_irq: assert property (p_irq) else $error("pa2 owner wrong");
    property p_xrst; ext_reset_en |=> !key_irq_line_r[3] && !port_a_oe_r[3]; endproperty
    a_xrst: assert property (p_xrst) else $error("pa3 owner wrong");
    property p_oso; osc_out_pin_enable |=> port_a_oe_r[4] && port_a_out_r[4] == $past(rc_clock); endproperty
    a_oso: assert property (p_oso) else $error("pa4 clock missing");
    property p_osi; oscillator_in_en |=> !port_a_oe_r[5] && !key_irq_line_r[5] && oscillator_in_r == $past(port_a_pin_in[5]); endproperty
    a_osi: assert property (p_osi) else $error("pa5 owner wrong");
    property p_adb; (port_b_oe_r[5:0] & $past(analog_sel_b[5:0])) == 6'h00; endproperty
    a_adb: assert property (p_adb) else $error("port b analog pin driven");
    property p_spi; spi_en && !analog_sel_b[2] |=> port_b_oe_r[2] == $past(spi_oe[2]); endproperty
    a_spi: assert property (p_spi) else $error("pb2 spi drive wrong");
    property p_ser; serial_en && !analog_sel_b[5] |=> port_b_oe_r[5] == $past(serial_oe[1]); endproperty
    a_ser: assert property (p_ser) else $error("pb5 serial drive wrong");
    property p_tch; timer_chan_en[2] |=> port_b_oe_r[6] == $past(timer_chan_oe[2]); endproperty
    a_tch: assert property (p_tch) else $error("pb6 timer drive wrong");
endmodule
bind shared_pin_priority_mux pin_mux_chk chk_i (.*);

/* shared_pin_priority_mux_bench.sv */
/* Self-checking bench for the pin selection block.
   Assumes the board model drives undriven pins; checker is bound separately. */
`timescale 1ns/100ps
module shared_pin_priority_mux_bench;
    reg         clk = 1'b0, rstn = 1'b1;
    reg  [5:0]  port_a_ddr = 6'h00, port_a_dout = 6'h00, analog_sel_a = 6'h00, key_irq_en = 6'h00;
    reg  [7:0]  port_b_ddr = 8'h00, port_b_dout = 8'h00, analog_sel_b = 8'h00;
    reg  [3:0]  timer_chan_en = 4'h0, timer_chan_oe = 4'h0, timer_chan_out = 4'h0;
    reg  [3:0]  spi_oe = 4'h0, spi_out = 4'h0;
    reg  [1:0]  serial_oe = 2'h0, serial_out = 2'h0;
    reg         timer_ext_clock_en = 1'b0, ext_irq_en = 1'b0, ext_reset_en = 1'b0, xtal_out = 1'b0;
    reg         oscillator_in_en = 1'b0, xtal_out_en = 1'b0, osc_out_pin_enable = 1'b0;
    reg         rc_clock = 1'b0, spi_en = 1'b0, serial_en = 1'b0;
    reg  [13:0] board = 14'h0000; // Board level on undriven pins
    wire [5:0]  port_a_pin_in, port_a_oe_r, port_a_out_r, key_irq_line_r;
    wire [7:0]  port_b_pin_in, port_b_oe_r, port_b_out_r;
    wire        ext_irq_line_r, ext_reset_line_r, timer_ext_clock_in_r, oscillator_in_r;
    integer     err_count = 0, total_checks = 0;
    always #20 clk = ~clk;
    shared_pin_priority_mux uut (.*);
    pin_board board_model (.oe({port_b_oe_r, port_a_oe_r}), .dout({port_b_out_r, port_a_out_r}),
        .ext(board), .pin({port_b_pin_in, port_a_pin_in}));
    // Outputs land one edge after the drive; look just past that edge
    task want(input [7:0] boe, bout, input [5:0] aoe, aout, key, input [3:0] misc);
        @(posedge clk);
        #1;
        total_checks = total_checks + 1;
        if ({port_b_oe_r, port_b_out_r, port_a_oe_r, port_a_out_r, key_irq_line_r, ext_irq_line_r,
             ext_reset_line_r, timer_ext_clock_in_r, oscillator_in_r} !== {boe, bout, aoe, aout, key, misc}) begin
            err_count = err_count + 1;
            $display("[ERR] %0t exp %h got %h", $time, {boe, bout, aoe, aout, key, misc},
                {port_b_oe_r, port_b_out_r, port_a_oe_r, port_a_out_r, key_irq_line_r,
                 ext_irq_line_r, ext_reset_line_r, timer_ext_clock_in_r, oscillator_in_r});
        end
    endtask
    // Everything off, so each scenario starts from all inputs
    task clr;
        @(posedge clk) {port_a_ddr, port_a_dout, analog_sel_a, key_irq_en, port_b_ddr, port_b_dout,
            analog_sel_b, timer_chan_en, timer_chan_oe, timer_chan_out, spi_oe, spi_out, serial_oe,
            serial_out, timer_ext_clock_en, ext_irq_en, ext_reset_en, xtal_out, oscillator_in_en,
            xtal_out_en, osc_out_pin_enable, rc_clock, spi_en, serial_en, board} <= '0;
    endtask
    task t_reset;
        rstn <= 1'b0;
        @(posedge clk) {port_a_ddr, port_a_dout, port_b_ddr, port_b_dout} <= 28'hfff_ffff;
        want(8'h00, 8'h00, 6'h00, 6'h00, 6'h00, 4'h0);
        repeat (3) @(posedge clk);
        @(posedge clk) rstn <= 1'b1;
        want(8'hff, 8'hff, 6'h3b, 6'h3b, 6'h00, 4'h0);
        $display("t_reset done");
    endtask
    task t_pa0;
        clr;
        @(posedge clk) {timer_chan_en, timer_chan_oe, timer_chan_out, key_irq_en[0], port_a_ddr[0], port_b_ddr[6]} <= 15'h2aaf;
        want(8'h40, 8'h40, 6'h01, 6'h01, 6'h00, 4'h0);
        @(posedge clk) analog_sel_a[0] <= 1'b1;
        want(8'h40, 8'h40, 6'h00, 6'h00, 6'h00, 4'h0);
        @(posedge clk) {analog_sel_a[0], timer_chan_en, board[0]} <= 6'h01;
        want(8'h40, 8'h00, 6'h00, 6'h00, 6'h01, 4'h0);
        @(posedge clk) key_irq_en[0] <= 1'b0;
        want(8'h40, 8'h00, 6'h01, 6'h00, 6'h00, 4'h0);
        $display("t_pa0 done");
    endtask
    task t_pa23;
        clr;
        @(posedge clk) {ext_irq_en, timer_ext_clock_en, ext_reset_en, key_irq_en[3:2], port_a_ddr[3:2], board[3:2]} <= 9'h1ff;
        want(8'h00, 8'h00, 6'h00, 6'h00, 6'h00, 4'hc);
        @(posedge clk) {ext_irq_en, ext_reset_en} <= 2'h0;
        want(8'h00, 8'h00, 6'h00, 6'h00, 6'h08, 4'h2);
        @(posedge clk) {timer_ext_clock_en, key_irq_en[3]} <= 2'h0;
        want(8'h00, 8'h00, 6'h08, 6'h00, 6'h04, 4'h0);
        $display("t_pa23 done");
    endtask
    task t_pa45;
        clr;
        @(posedge clk) {osc_out_pin_enable, rc_clock, xtal_out_en, analog_sel_a[4], key_irq_en[5:4], oscillator_in_en, analog_sel_a[5], board[5]} <= 9'h1ff;
        want(8'h00, 8'h00, 6'h10, 6'h10, 6'h00, 4'h1);
        @(posedge clk) {osc_out_pin_enable, oscillator_in_en} <= 2'h0;
        want(8'h00, 8'h00, 6'h10, 6'h00, 6'h00, 4'h0);
        @(posedge clk) {xtal_out_en, analog_sel_a[5:4]} <= 3'h0;
        want(8'h00, 8'h00, 6'h00, 6'h00, 6'h20, 4'h0);
        $display("t_pa45 done");
    endtask
    task t_pb;
        clr;
        @(posedge clk) {spi_en, spi_oe, spi_out, serial_en, serial_oe, serial_out, analog_sel_b[0], port_b_ddr[5:0]} <= 21'h1f_5f7f;
        want(8'h3e, 8'h24, 6'h00, 6'h00, 6'h00, 4'h0);
        @(posedge clk) {spi_en, serial_en, analog_sel_b[0]} <= 3'h0;
        want(8'h3f, 8'h00, 6'h00, 6'h00, 6'h00, 4'h0);
        // Analog use kept as software should: direction input, sharers off
        @(posedge clk) {analog_sel_b[1], port_b_ddr[1]} <= 2'h2;
        want(8'h3d, 8'h00, 6'h00, 6'h00, 6'h00, 4'h0);
        $display("t_pb done");
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        t_reset;
        t_pa0;
        t_pa23;
        t_pa45;
        t_pb;
        tally_and_finish;
    end
    // The tests need about 40 cycles; far beyond that means a hang
    initial begin
        #20000;
        err_count = err_count + 1;
        tally_and_finish;
    end
endmodule
